/* pkg/bme_params.svh */
// Purpose: Named constants of the decorated read-modify-write engine
// Assumes: 32-bit AHB-Lite on both sides
// Notes: Definitions only
`ifndef BME_PARAMS_SVH
`define BME_PARAMS_SVH
`define ADDR_KEEP_MASK 32'hE00F_FFFF
`define PERIPH_TAG 3'h2
`define OP_NONE 3'h0
`define OP_AND 3'h1
`define OP_OR 3'h2
`define OP_XOR 3'h3
`define OP_LD_CLR 3'h2
`define OP_LD_SET 3'h3
`define TRANS_IDLE 2'h0
`define TRANS_NONSEQ 2'h2
`define SIZE_BYTE 3'h0
`define SIZE_HALF 3'h1
`define FIELD_ONES 32'h0000_FFFF
`define WIDTH_MAX 4'hF
`define TAG_HI 31
`define TAG_LO 29
`define OP_HI 28
`define OP_LO 26
`define INS_LSB_HI 27
`define INS_LSB_LO 23
`define BIT_NUM_HI 25
`define BIT_NUM_LO 21
`define WIDTH_HI 22
`define WIDTH_LO 19
`endif

/* pkg/bme_pkg.sv */
// Purpose: Types of the decorated read-modify-write engine
// Assumes: Constants come from bme_params.svh
// Notes: One-hot sequence states
package bme_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_READ = 3'h2,
      ST_WRITE = 3'h4
   } rmw_state_t;
endpackage : bme_pkg

/* verilog/bit_manip_engine.sv */
// Purpose: In-line AHB stage turning decorated stores and bit clear/set loads into atomic RMW
// Assumes: One clock; only the core reaches this port
// Notes: Plain accesses pass combinationally
`timescale 1ns/1ps
`default_nettype none
`include "bme_params.svh"
module bit_manip_engine import bme_pkg::*; (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Crossbar side, AHB slave
   input wire logic xbar_hsel_i,
   input wire logic [31:0] xbar_haddr_i,
   input wire logic [1:0] xbar_htrans_i,
   input wire logic xbar_hwrite_i,
   input wire logic [2:0] xbar_hsize_i,
   input wire logic [3:0] xbar_hprot_i,
   input wire logic [31:0] xbar_hwdata_i,
   input wire logic xbar_hready_i,
   output logic [31:0] xbar_hrdata_o,
   output logic xbar_hready_o,
   output logic xbar_hresp_o,
   // Peripheral bridge side, AHB master
   output logic [31:0] brg_haddr_o,
   output logic [1:0] brg_htrans_o,
   output logic brg_hwrite_o,
   output logic [2:0] brg_hsize_o,
   output logic [3:0] brg_hprot_o,
   output logic [31:0] brg_hwdata_o,
   input wire logic [31:0] brg_hrdata_i,
   input wire logic brg_hready_i,
   input wire logic brg_hresp_i
);

   // ----------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------
   rmw_state_t state_q, state_d;
   logic [31:0] addr_q, hold_addr_q, wdata_q, rdata_q;
   logic [2:0] size_q, op_q;
   logic [3:0] prot_q, wm1_q;
   logic [4:0] lsb_q, lane_q;
   logic wr_q, load_q, ubfx_q;

   logic in_sel, accept, in_deco, in_ins, in_rmw, in_ubfx;
   logic [2:0] in_op;
   logic [4:0] in_lane, in_lsb;
   logic [31:0] fwd_addr;
   assign in_sel = xbar_hsel_i & xbar_htrans_i[1];
   assign accept = in_sel & xbar_hready_i;
   assign in_op = xbar_haddr_i[`OP_HI:`OP_LO];
   assign fwd_addr = xbar_haddr_i & `ADDR_KEEP_MASK;
   assign in_deco = (xbar_haddr_i[`TAG_HI:`TAG_LO] == `PERIPH_TAG)
                    & (in_op != `OP_NONE);
   assign in_ins = in_op[2];
   assign in_rmw = in_deco & (xbar_hwrite_i | (in_op == `OP_LD_CLR)
                   | (in_op == `OP_LD_SET));
   assign in_ubfx = in_deco & ~xbar_hwrite_i & in_ins;
   assign in_lane = (xbar_hsize_i == `SIZE_BYTE) ? {xbar_haddr_i[1:0], 3'h0} :
                    (xbar_hsize_i == `SIZE_HALF) ? {xbar_haddr_i[1], 4'h0} : 5'h00;
   assign in_lsb = in_lane + (in_ins ? xbar_haddr_i[`INS_LSB_HI:`INS_LSB_LO] :
                   xbar_haddr_i[`BIT_NUM_HI:`BIT_NUM_LO]);

   // ----------------------------------------------------------
   // Modify datapath
   // ----------------------------------------------------------
   logic [31:0] field_mask, bit_mask, store_res, load_res, bit_ret, ubfx_ret;
   assign field_mask = (`FIELD_ONES >> (`WIDTH_MAX - wm1_q)) << lsb_q;
   assign bit_mask = 32'h0000_0001 << lsb_q;
   assign store_res = (op_q == `OP_AND) ? (brg_hrdata_i & xbar_hwdata_i) :
                      (op_q == `OP_OR) ? (brg_hrdata_i | xbar_hwdata_i) :
                      (op_q == `OP_XOR) ? (brg_hrdata_i ^ xbar_hwdata_i) :
                      ((brg_hrdata_i & ~field_mask) | (xbar_hwdata_i & field_mask));
   assign load_res = (op_q == `OP_LD_SET) ? (brg_hrdata_i | bit_mask) :
                     (brg_hrdata_i & ~bit_mask);
   assign bit_ret = {31'h0000_0000, |(brg_hrdata_i & bit_mask)} << lane_q;
   assign ubfx_ret = ((brg_hrdata_i & field_mask) >> lsb_q) << lane_q;

   // ----------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE, ST_WRITE: begin
            if (xbar_hready_o) begin
               state_d = (accept & in_rmw) ? ST_READ : ST_IDLE;
            end
         end
         ST_READ: begin
            if (brg_hready_i) begin
               state_d = brg_hresp_i ? ST_IDLE : ST_WRITE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_IDLE;
         ubfx_q <= 1'b0;
         hold_addr_q <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
         hold_addr_q <= brg_haddr_o;
         if (xbar_hready_o) begin
            ubfx_q <= accept & in_ubfx;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         addr_q <= 32'h0000_0000;
         size_q <= 3'h0;
         prot_q <= 4'h0;
         op_q <= 3'h0;
         wm1_q <= 4'h0;
         lsb_q <= 5'h00;
         lane_q <= 5'h00;
         wr_q <= 1'b0;
      end else if (accept & in_deco & xbar_hready_o) begin
         addr_q <= fwd_addr;
         size_q <= xbar_hsize_i;
         prot_q <= xbar_hprot_i;
         op_q <= in_op;
         wm1_q <= xbar_haddr_i[`WIDTH_HI:`WIDTH_LO];
         lsb_q <= in_lsb;
         lane_q <= in_lane;
         wr_q <= xbar_hwrite_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wdata_q <= 32'h0000_0000;
         rdata_q <= 32'h0000_0000;
         load_q <= 1'b0;
      end else if ((state_q == ST_READ) & brg_hready_i) begin
         wdata_q <= wr_q ? store_res : load_res;
         rdata_q <= bit_ret;
         load_q <= ~wr_q;
      end
   end

   // ----------------------------------------------------------
   // Output buses
   // ----------------------------------------------------------
   logic in_rd;
   assign in_rd = state_q == ST_READ;
   always_comb begin
      if (in_rd) begin
         brg_haddr_o = addr_q;
         brg_htrans_o = brg_hresp_i ? `TRANS_IDLE : `TRANS_NONSEQ;
         brg_hwrite_o = 1'b1;
         brg_hsize_o = size_q;
         brg_hprot_o = prot_q;
      end else begin
         brg_haddr_o = in_sel ? fwd_addr : hold_addr_q;
         brg_htrans_o = in_sel ? xbar_htrans_i : `TRANS_IDLE;
         brg_hwrite_o = xbar_hwrite_i & ~in_deco;
         brg_hsize_o = xbar_hsize_i;
         brg_hprot_o = xbar_hprot_i;
      end
   end
   assign brg_hwdata_o = (state_q == ST_WRITE) ? wdata_q : xbar_hwdata_i;
   assign xbar_hready_o = in_rd ? (brg_hready_i & brg_hresp_i) : brg_hready_i;
   assign xbar_hresp_o = brg_hresp_i;
   assign xbar_hrdata_o = ((state_q == ST_WRITE) & load_q) ? rdata_q :
                          ubfx_q ? ubfx_ret : brg_hrdata_i;

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   property p_first_read;
      accept & in_rmw & xbar_hready_o |-> !brg_hwrite_o && brg_haddr_o == fwd_addr
         ##1 addr_q == $past(fwd_addr);
   endproperty
   a_first_read: assert property (p_first_read) else $error("rmw first phase not a read");
   property p_wr_addr;
      in_rd & !brg_hresp_i |-> brg_htrans_o == `TRANS_NONSEQ && brg_hwrite_o
         && brg_haddr_o == addr_q && !xbar_hready_o;
   endproperty
   a_wr_addr: assert property (p_wr_addr) else $error("write-back address phase wrong");
   property p_wb_data;
      in_rd & brg_hready_i & !brg_hresp_i & wr_q |=> state_q == ST_WRITE
         && brg_hwdata_o == $past(store_res);
   endproperty
   a_wb_data: assert property (p_wb_data) else $error("write-back data wrong");
   property p_and;
      in_rd & brg_hready_i & wr_q & (op_q == `OP_AND) |=>
         wdata_q == ($past(brg_hrdata_i) & $past(xbar_hwdata_i));
   endproperty
   a_and: assert property (p_and) else $error("AND result wrong");
   property p_or;
      in_rd & brg_hready_i & wr_q & (op_q == `OP_OR) |=>
         wdata_q == ($past(brg_hrdata_i) | $past(xbar_hwdata_i));
   endproperty
   a_or: assert property (p_or) else $error("OR result wrong");
   property p_wait;
      !in_rd |-> xbar_hready_o == brg_hready_i;
   endproperty
   a_wait: assert property (p_wait) else $error("wait state not passed");
   property p_strip;
      brg_htrans_o[1] |-> (brg_haddr_o & ~`ADDR_KEEP_MASK) == 32'h0000_0000;
   endproperty
   a_strip: assert property (p_strip) else $error("decoration not stripped");
   property p_err;
      in_rd & brg_hresp_i & brg_hready_i |-> xbar_hresp_o && xbar_hready_o
         ##1 state_q == ST_IDLE;
   endproperty
   a_err: assert property (p_err) else $error("read error not returned");
   property p_plain;
      accept & !in_deco & !in_rd |-> brg_htrans_o == xbar_htrans_i
         && brg_hwrite_o == xbar_hwrite_i ##1 state_q == ST_IDLE;
   endproperty
   a_plain: assert property (p_plain) else $error("plain access not passed");
   property p_hold;
      !brg_htrans_o[1] & !in_rd |-> brg_haddr_o == $past(brg_haddr_o);
   endproperty
   a_hold: assert property (p_hold) else $error("idle address toggled");
   property p_xor;
      in_rd & brg_hready_i & wr_q & (op_q == `OP_XOR) |=>
         wdata_q == ($past(brg_hrdata_i) ^ $past(xbar_hwdata_i));
   endproperty
   a_xor: assert property (p_xor) else $error("XOR result wrong");
   property p_ins;
      in_rd & brg_hready_i & wr_q & op_q[2] |=>
         (wdata_q & ~$past(field_mask)) == ($past(brg_hrdata_i) & ~$past(field_mask));
   endproperty
   a_ins: assert property (p_ins) else $error("insert touched bits outside field");
   property p_load_bit;
      in_rd & brg_hready_i & !brg_hresp_i & !wr_q |=>
         (|(wdata_q & $past(bit_mask))) == (op_q == `OP_LD_SET);
   endproperty
   a_load_bit: assert property (p_load_bit) else $error("load set or clear wrong");
   property p_lane;
      in_rd & brg_hready_i & !brg_hresp_i & !wr_q |=>
         (rdata_q & ~(32'h0000_0001 << lane_q)) == 32'h0000_0000;
   endproperty
   a_lane: assert property (p_lane) else $error("returned bit off its lane");
   property p_ubfx;
      ubfx_q & brg_hready_i |-> ((xbar_hrdata_o >> lane_q)
         & ~(`FIELD_ONES >> (`WIDTH_MAX - wm1_q))) == 32'h0000_0000;
   endproperty
   a_ubfx: assert property (p_ubfx) else $error("extract wider than field");
   property p_attr;
      accept & in_rmw & xbar_hready_o & !in_rd |=> in_rd && brg_hsize_o == $past(xbar_hsize_i)
         && brg_hprot_o == $past(xbar_hprot_i);
   endproperty
   a_attr: assert property (p_attr) else $error("write-back attributes wrong");
   property p_err_wr;
      (state_q == ST_WRITE) & brg_hresp_i |-> xbar_hresp_o && xbar_hready_o == brg_hready_i;
   endproperty
   a_err_wr: assert property (p_err_wr) else $error("write-back error not passed");
   property p_pass_addr;
      accept & !in_rd |-> brg_haddr_o == fwd_addr && brg_hsize_o == xbar_hsize_i;
   endproperty
   a_pass_addr: assert property (p_pass_addr) else $error("address not forwarded");
   property p_idle_trans;
      !in_sel & !in_rd |-> brg_htrans_o == `TRANS_IDLE;
   endproperty
   a_idle_trans: assert property (p_idle_trans) else $error("spurious output transfer");
   property p_rd_hold;
      in_rd & !brg_hready_i |=> in_rd && addr_q == $past(addr_q);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read phase not stretched");

   // ----------------------------------------------------------
   // Cover points
   // ----------------------------------------------------------
   c_and: cover property (in_rd & wr_q & (op_q == `OP_AND) ##1 state_q == ST_WRITE);
   c_ins: cover property (in_rd & wr_q & op_q[2] ##1 state_q == ST_WRITE);
   c_ubfx: cover property (ubfx_q & brg_hready_i);
   c_err: cover property (in_rd & brg_hresp_i & brg_hready_i);
   c_ldbit: cover property (in_rd & !wr_q & brg_hready_i ##1 state_q == ST_WRITE);

endmodule : bit_manip_engine
`default_nettype wire

/* dv/brg_slave_model.sv */
// Purpose: Peripheral bridge slave model with word memory
// Assumes: AHB-Lite slave, waits set by the bench, word 15 answers ERROR
// Notes: Read data is inverted outside a completing read
`timescale 1ns/1ps
`default_nettype none
module brg_slave_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Bus from the engine, waits from the bench
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic [3:0] waits_i,
   // Response
   output logic [31:0] hrdata_o,
   output logic hready_o,
   output logic hresp_o
);
   logic [31:0] mem [16];
   logic act_q, wr_q, err_q, errh_q;
   logic [3:0] idx_q, be_q, cnt_q;
   logic [31:0] last_q;
   wire logic [3:0] be_d = (hsize_i == 3'h0) ? 4'h1 << haddr_i[1:0] :
      (hsize_i == 3'h1) ? 4'h3 << {haddr_i[1], 1'b0} : 4'hF;
   assign hready_o = !act_q || (err_q ? errh_q : (cnt_q >= waits_i));
   assign hresp_o = act_q && err_q;
   assign hrdata_o = (act_q && !wr_q && hready_o) ? mem[idx_q] : ~last_q;
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         act_q <= 1'b0;
         cnt_q <= 4'h0;
         last_q <= 32'h0;
         err_q <= 1'b0;
         errh_q <= 1'b0;
      end else begin
         last_q <= hrdata_o;
         if (hready_o) begin
            for (int b = 0; b < 4; b++) begin
               if (act_q && wr_q && !err_q && be_q[b]) mem[idx_q][8*b+:8] <= hwdata_i[8*b+:8];
            end
            act_q <= htrans_i[1];
            wr_q <= hwrite_i;
            idx_q <= haddr_i[5:2];
            be_q <= be_d;
            cnt_q <= 4'h0;
            err_q <= htrans_i[1] && (haddr_i[5:2] == 4'hF);
            errh_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q + 4'h1;
            errh_q <= err_q;
         end
      end
   end
endmodule : brg_slave_model
`default_nettype wire

/* dv/test_bit_manip_engine.sv */
// Purpose: Bench of the decorated read-modify-write engine
// Assumes: Core is the only master
// Notes: Bridge memory is set and read directly
`timescale 1ns/1ps
`default_nettype none
`include "bme_params.svh"
module test_bit_manip_engine;
   logic clk_sys_i = 0, reset_n_i = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] waits = 4'h0;
   logic [3:0] hprot = 4'h3;
   wire logic [3:0] b_hprot;
   wire logic [31:0] hrdata, b_haddr, b_hwdata, b_hrdata;
   wire logic hready, hresp, b_hwrite, b_hready, b_hresp;
   wire logic [1:0] b_htrans;
   wire logic [2:0] b_hsize;
   int num_errors = 0, checks_done = 0;
   always #12.5 clk_sys_i = ~clk_sys_i;
   bit_manip_engine bit_manip_engine_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .xbar_hsel_i(hsel), .xbar_haddr_i(haddr), .xbar_htrans_i(htrans), .xbar_hwrite_i(hwrite),
      .xbar_hsize_i(hsize), .xbar_hprot_i(hprot), .xbar_hwdata_i(hwdata), .xbar_hready_i(hready),
      .xbar_hrdata_o(hrdata), .xbar_hready_o(hready), .xbar_hresp_o(hresp),
      .brg_haddr_o(b_haddr), .brg_htrans_o(b_htrans), .brg_hwrite_o(b_hwrite),
      .brg_hsize_o(b_hsize), .brg_hprot_o(b_hprot), .brg_hwdata_o(b_hwdata),
      .brg_hrdata_i(b_hrdata),
      .brg_hready_i(b_hready), .brg_hresp_i(b_hresp));
   brg_slave_model brg_slave_model_inst (.clk_i(clk_sys_i), .reset_n_i(reset_n_i),
      .haddr_i(b_haddr), .htrans_i(b_htrans), .hwrite_i(b_hwrite), .hsize_i(b_hsize),
      .hwdata_i(b_hwdata), .waits_i(waits), .hrdata_o(b_hrdata), .hready_o(b_hready),
      .hresp_o(b_hresp));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("Checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wait_rdy(output int n);
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
         if (n > 50) begin
            num_errors++;
            stop_test();
         end
      end while (hready !== 1'b1);
   endtask : wait_rdy
   task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s,
         input logic [31:0] wd, input int cyc, output logic [31:0] r);
      int n;
      @(posedge clk_sys_i);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= `TRANS_NONSEQ;
      hwrite <= w;
      hsize <= s;
      hprot <= {w, s};
      wait_rdy(n);
      check(b_haddr, a & `ADDR_KEEP_MASK);
      check({31'h0, b_hwrite}, {31'h0, (a[31:26] > 6'h10) ? 1'b0 : w});
      check({28'h0, b_hprot}, {28'h0, w, s});
      check({29'h0, b_hsize}, {29'h0, s});
      @(posedge clk_sys_i);
      hwdata <= wd;
      htrans <= `TRANS_IDLE;
      hsel <= 1'b0;
      wait_rdy(n);
      r = hrdata;
      check(32'(n), 32'(cyc));
      check({31'h0, hresp}, {31'h0, (a[5:2] == 4'hF)});
      @(posedge clk_sys_i);
      #1;
   endtask : xfer
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_plain();
      xfer(32'h4000_0004, 1'b1, 3'h2, 32'h1234_5678, 1, rd);
      check(brg_slave_model_inst.mem[1], 32'h1234_5678);
      xfer(32'h4000_0004, 1'b0, 3'h2, 32'h0, 1, rd);
      check(rd, 32'h1234_5678);
   endtask : t_plain
   task automatic t_logic();
      logic [31:0] e;
      for (int op = 1; op < 4; op++) begin
         brg_slave_model_inst.mem[2] = 32'hF0F0_A5A5;
         xfer({3'h2, op[2:0], 26'h8}, 1'b1, 3'h2, 32'h0FF0_3C3C, 2, rd);
         e = (op == 1) ? 32'hF0F0_A5A5 & 32'h0FF0_3C3C :
            (op == 2) ? 32'hF0F0_A5A5 | 32'h0FF0_3C3C : 32'hF0F0_A5A5 ^ 32'h0FF0_3C3C;
         check(brg_slave_model_inst.mem[2], e);
      end
      brg_slave_model_inst.mem[3] = 32'h1111_1111;
      xfer(32'h4800_000D, 1'b1, 3'h0, 32'h8080_8080, 2, rd);
      check(brg_slave_model_inst.mem[3], 32'h1111_9111);
   endtask : t_logic
   task automatic t_field();
      logic [31:0] a;
      a = 32'h5000_0010 | (32'h4 << 23) | (32'h7 << 19);
      brg_slave_model_inst.mem[4] = 32'hAAAA_AAAA;
      xfer(a, 1'b1, 3'h2, 32'h1234_5678, 2, rd);
      check(brg_slave_model_inst.mem[4], 32'hAAAA_A67A);
      xfer(a, 1'b0, 3'h2, 32'h0, 1, rd);
      check(rd, 32'h67);
      brg_slave_model_inst.mem[5] = 32'hF0;
      xfer(32'h4C00_0014 | (32'h3 << 21), 1'b0, 3'h2, 32'h0, 2, rd);
      check(rd, 32'h0);
      xfer(32'h4800_0014 | (32'h4 << 21), 1'b0, 3'h2, 32'h0, 2, rd);
      check(rd, 32'h1);
      check(brg_slave_model_inst.mem[5], 32'hE8);
   endtask : t_field
   task automatic t_waits();
      waits <= 4'h2;
      xfer(32'h4000_0004, 1'b0, 3'h2, 32'h0, 3, rd);
      brg_slave_model_inst.mem[2] = 32'h00FF_00FF;
      xfer(32'h4400_0008, 1'b1, 3'h2, 32'h0F0F_0F0F, 6, rd);
      check(brg_slave_model_inst.mem[2], 32'h000F_000F);
      waits <= 4'h0;
   endtask : t_waits
   task automatic t_error();
      brg_slave_model_inst.mem[15] = 32'h5A5A_5A5A;
      xfer(32'h4400_003C, 1'b1, 3'h2, 32'h0000_0000, 2, rd);
      check(brg_slave_model_inst.mem[15], 32'h5A5A_5A5A);
      xfer(32'h4000_003C, 1'b1, 3'h2, 32'h1111_1111, 2, rd);
      check(brg_slave_model_inst.mem[15], 32'h5A5A_5A5A);
      xfer(32'h4000_0004, 1'b0, 3'h2, 32'h0, 1, rd);
      check(rd, 32'h1234_5678);
   endtask : t_error
   initial begin
      repeat (5) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      t_plain();
      t_logic();
      t_field();
      t_waits();
      t_error();
      stop_test();
   end
endmodule : test_bit_manip_engine
`default_nettype wire
